// *** logic/gdc_ctrl_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// R1 - Pump mode 00: pumps run, trickle switch on while driver enable is 0
// R2 - Pump mode 01: pump-to-phase switch open, pump clock keeps running
// R3 - Pump mode 10: pump-to-phase switch and pump clock both off
// R4 - Pump mode 11: pumps run, trickle switch off while driver enable is 0
// R5 - Host keeps pump mode 00 to hold bootstrap charge with driver disabled
// R6 - Lock code 011 unlocks; other codes except 110 ignored; resets to 3
// R7 - Lock code 110 locks; later writes ignored except to the lock field
// R8 - Fault clear of 1 clears latched faults and self-clears; 0 does nothing
// R9 - Fault clear and driver enable in one frame: clear wins, enable stays 0; code keeps enable 0 only while a fault is latched
// R10 - Host should clear faults first, then enable in a later frame
// R11 - Frame is 8-bit command plus 16-bit data, plus 8-bit CRC when enabled
// R12 - Warning report bit set: warnings also pull the fault pin low
// R13 - Spread spectrum bit 1 disables oscillator spreading, 0 keeps it
// R14 - Trickle pump starts 100 or 250 us after all PWM inputs go low
// R15 - Overtemp field: 00 warning, 01 fault with shutdown, 1x nothing
// R16 - Driver enable forced 0 while a fault exists or disable pin is high
// R17 - Reserved bits read as zero and ignore writes
module gdc_ctrl_regs
    import gdc_pkg::*;
#(
    parameter int TRICKLE_LONG = gdc_pkg::TRICKLE_LONG_CYC
)
(
    clk,
    rstn,
    sclk,
    cs_n,
    sdi,
    sdo_o,
    sdo_oe,
    pins,
    pump,
    gate_enable,
    fault_clear,
    overtemp_shutdown,
    spread_spectrum_off,
    fault_pin_n_o,
    fault_pin_n_oe,
    crc_error,
    frame_error
);
    input wire logic clk;
    input wire logic rstn;
    input wire logic sclk;
    input wire logic cs_n;
    input wire logic sdi;
    output logic sdo_o;
    output logic sdo_oe;
    input wire gdc_pkg::gdc_pins_t pins;
    output gdc_pkg::gdc_pump_t pump;
    output logic gate_enable;
    output logic fault_clear;
    output logic overtemp_shutdown;
    output logic spread_spectrum_off;
    output logic fault_pin_n_o;
    output logic fault_pin_n_oe;
    output logic crc_error;
    output logic frame_error;

    import gdc_pkg::*;

    localparam logic [TIMER_W-1:0] SHORT_LIM = TIMER_W'(TRICKLE_SHORT_CYC);
    localparam logic [TIMER_W-1:0] LONG_LIM = TIMER_W'(TRICKLE_LONG);

    // ----------------
    // Reset release and input synchronisers
    // ----------------
    logic rst_meta_ff, rst_sync_ff;
    logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
    gdc_pins_t pin_meta_ff, pin_ff;

    // Reset asserts at once, releases two edges later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Pins and link select pass two flops before use
    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
            pin_meta_ff <= '0;
            pin_ff <= '0;
        end else begin
            cs_meta_ff <= cs_n;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
            pin_meta_ff <= pins;
            pin_ff <= pin_meta_ff;
        end
    end

    // ----------------
    // Link side shifter
    // ----------------
    gdc_shadow_t shadow_ff, nxt_shadow;
    gdc_frame_t frame;

    gdc_spi_link u_link (
        .sclk(sclk),
        .rst_n(rst_sync_ff),
        .cs_n(cs_n),
        .sdi(sdi),
        .shadow(shadow_ff),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe),
        .frame(frame)
    );

    // ----------------
    // Frame decode
    // ----------------
    logic crc_en_ff, nxt_crc_en;
    logic frame_done, len_ok, crc_ok, wr_ok;
    logic [CMD_W-1:0] cmd;
    logic [DATA_W-1:0] wdata;
    logic [CRC_W-1:0] rx_crc;

    // Frame bits are stable: link clock idles while select is high
    always_comb begin
        frame_done = cs_sync_ff & ~cs_prev_ff;
        if (crc_en_ff) begin
            cmd = frame.bits[31:24];
            wdata = frame.bits[23:8];
            rx_crc = frame.bits[7:0];
            len_ok = (frame.count == FRAME_BITS_CRC); // [R11]
        end else begin
            cmd = frame.bits[23:16];
            wdata = frame.bits[15:0];
            rx_crc = 8'h00;
            len_ok = (frame.count == FRAME_BITS_PLAIN); // [R11]
        end
        crc_ok = ~crc_en_ff | (gdc_crc8({cmd, wdata}) == rx_crc); // [R11]
        wr_ok = frame_done & len_ok & crc_ok & ~cmd[CMD_READ_BIT];
    end

    // ----------------
    // Second control register
    // ----------------
    logic de_ff, nxt_de;
    logic [1:0] pump_mode_sel_ff, nxt_pump_mode_sel;
    logic [2:0] lock_ff, nxt_lock;
    logic clr_ff, nxt_clr;
    logic locked, wr_two, wr_three, force_off;

    always_comb begin
        locked = (lock_ff == LOCK_SHUT);
        wr_two = wr_ok && (cmd[ADDR_W-1:0] == ADDR_IC_CONTROL_TWO);
        wr_three = wr_ok && (cmd[ADDR_W-1:0] == ADDR_IC_CONTROL_THREE);
        force_off = pin_ff.fault_present | pin_ff.driver_disable_pin | overtemp_shutdown;
        nxt_de = de_ff;
        nxt_pump_mode_sel = pump_mode_sel_ff;
        nxt_lock = lock_ff;
        nxt_clr = 1'b0; // Self-clearing [R8]
        if (wr_two) begin
            // Only the two listed codes move the lock state
            if (wdata[LOCK_LSB+:3] == LOCK_OPEN || wdata[LOCK_LSB+:3] == LOCK_SHUT) begin
                nxt_lock = wdata[LOCK_LSB+:3]; // [R6] [R7]
            end
            if (!locked) begin // [R7]
                nxt_pump_mode_sel = wdata[PUMP_MODE_LSB+:2];
                nxt_clr = wdata[FAULT_CLEAR_BIT]; // [R8]
                // Clear has priority over enable while a fault waits
                nxt_de = wdata[DRIVER_ENABLE_BIT]
                    & ~(wdata[FAULT_CLEAR_BIT] & pin_ff.fault_latched); // [R9]
            end
        end
        if (force_off) begin
            nxt_de = 1'b0; // [R16]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            de_ff <= IC_CONTROL_TWO_RST[DRIVER_ENABLE_BIT];
            pump_mode_sel_ff <= IC_CONTROL_TWO_RST[PUMP_MODE_LSB+:2];
            lock_ff <= IC_CONTROL_TWO_RST[LOCK_LSB+:3];
            clr_ff <= 1'b0;
        end else begin
            de_ff <= nxt_de;
            pump_mode_sel_ff <= nxt_pump_mode_sel;
            lock_ff <= nxt_lock;
            clr_ff <= nxt_clr;
        end
    end

    // ----------------
    // Third control register
    // ----------------
    logic warn_rep_ff, nxt_warn_rep;
    logic ssc_off_ff, nxt_ssc_off;
    logic tdly_ff, nxt_tdly;
    logic [1:0] ot_sel_ff, nxt_ot_sel;

    // Reserved positions are never stored [R17]
    always_comb begin
        nxt_crc_en = crc_en_ff;
        nxt_warn_rep = warn_rep_ff;
        nxt_ssc_off = ssc_off_ff;
        nxt_tdly = tdly_ff;
        nxt_ot_sel = ot_sel_ff;
        if (wr_three && !locked) begin // [R7]
            nxt_crc_en = wdata[CRC_EN_BIT]; // [R11]
            nxt_warn_rep = wdata[WARN_REPORT_BIT];
            nxt_ssc_off = wdata[SSC_OFF_BIT];
            nxt_tdly = wdata[TRICKLE_DLY_BIT];
            nxt_ot_sel = wdata[OT_MODE_LSB+:2];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            crc_en_ff <= IC_CONTROL_THREE_RST[CRC_EN_BIT];
            warn_rep_ff <= IC_CONTROL_THREE_RST[WARN_REPORT_BIT];
            ssc_off_ff <= IC_CONTROL_THREE_RST[SSC_OFF_BIT];
            tdly_ff <= IC_CONTROL_THREE_RST[TRICKLE_DLY_BIT];
            ot_sel_ff <= IC_CONTROL_THREE_RST[OT_MODE_LSB+:2];
        end else begin
            crc_en_ff <= nxt_crc_en;
            warn_rep_ff <= nxt_warn_rep;
            ssc_off_ff <= nxt_ssc_off;
            tdly_ff <= nxt_tdly;
            ot_sel_ff <= nxt_ot_sel;
        end
    end

    // ----------------
    // Readback shadow for the link
    // ----------------
    // Refreshed only while select is idle so the link sees a frozen word
    always_comb begin
        nxt_shadow = shadow_ff;
        if (cs_sync_ff) begin
            nxt_shadow.control_two = '0; // [R17]
            nxt_shadow.control_two[DRIVER_ENABLE_BIT] = de_ff;
            nxt_shadow.control_two[PUMP_MODE_LSB+:2] = pump_mode_sel_ff;
            nxt_shadow.control_two[LOCK_LSB+:3] = lock_ff;
            nxt_shadow.control_three = '0; // [R17]
            nxt_shadow.control_three[CRC_EN_BIT] = crc_en_ff;
            nxt_shadow.control_three[WARN_REPORT_BIT] = warn_rep_ff;
            nxt_shadow.control_three[SSC_OFF_BIT] = ssc_off_ff;
            nxt_shadow.control_three[TRICKLE_DLY_BIT] = tdly_ff;
            nxt_shadow.control_three[OT_MODE_LSB+:2] = ot_sel_ff;
        end
    end

    // ------------------------------------------------------------
    // Trickle start timer and pump switches
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] tcnt_ff, nxt_tcnt, tlim;
    gdc_pump_t pump_ff, nxt_pump;
    logic pwm_idle, trickle_due;

    always_comb begin
        pwm_idle = ~|{pin_ff.high_side_pwm_in, pin_ff.low_side_pwm_in};
        tlim = tdly_ff ? LONG_LIM : SHORT_LIM; // [R14]
        trickle_due = (tcnt_ff == tlim);
        nxt_tcnt = tcnt_ff;
        if (!pwm_idle) begin
            nxt_tcnt = '0;
        end else if (tcnt_ff < tlim) begin
            nxt_tcnt = tcnt_ff + 1'b1; // [R14]
        end else begin
            nxt_tcnt = tlim;
        end
        nxt_pump.pump_clock_on = 1'b1;
        nxt_pump.pump_to_phase_node_on = 1'b1;
        nxt_pump.trickle_pump_switch_on = ~de_ff; // [R1]
        case (pump_mode_sel_ff)
            PUMP_NORMAL: begin
                nxt_pump.trickle_pump_switch_on = ~de_ff; // [R1]
            end
            PUMP_PHASE_OFF: begin
                nxt_pump.pump_to_phase_node_on = 1'b0; // [R2]
            end
            PUMP_SHUTDOWN: begin
                nxt_pump.pump_clock_on = 1'b0; // [R3]
                nxt_pump.pump_to_phase_node_on = 1'b0; // [R3]
                nxt_pump.trickle_pump_switch_on = 1'b0;
            end
            default: begin
                nxt_pump.trickle_pump_switch_on = de_ff; // [R4]
            end
        endcase
        nxt_pump.trickle_pump_run = nxt_pump.pump_clock_on & trickle_due; // [R14]
    end

    // ------------------------------------------------------------
    // Fault pin, overtemperature and status pulses
    // ------------------------------------------------------------
    logic ot_shut_ff, nxt_ot_shut;
    logic fault_low_ff, nxt_fault_low;
    logic crc_err_ff, nxt_crc_err;
    logic frame_err_ff, nxt_frame_err;
    logic ot_warn;

    always_comb begin
        ot_warn = pin_ff.overtemp_event & (ot_sel_ff == OT_WARNING); // [R15]
        nxt_ot_shut = pin_ff.overtemp_event & (ot_sel_ff == OT_SHUTDOWN); // [R15]
        // Warnings reach the pin only when reporting is on
        nxt_fault_low = pin_ff.fault_latched | ot_shut_ff
            | (warn_rep_ff & (pin_ff.warning_event | ot_warn)); // [R12]
        nxt_crc_err = frame_done & len_ok & ~crc_ok; // [R11]
        nxt_frame_err = frame_done & ~len_ok;
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            shadow_ff <= '{control_two: IC_CONTROL_TWO_RST,
                           control_three: IC_CONTROL_THREE_RST};
            tcnt_ff <= '0;
            pump_ff <= '0;
            ot_shut_ff <= 1'b0;
            fault_low_ff <= 1'b0;
            crc_err_ff <= 1'b0;
            frame_err_ff <= 1'b0;
        end else begin
            shadow_ff <= nxt_shadow;
            tcnt_ff <= nxt_tcnt;
            pump_ff <= nxt_pump;
            ot_shut_ff <= nxt_ot_shut;
            fault_low_ff <= nxt_fault_low;
            crc_err_ff <= nxt_crc_err;
            frame_err_ff <= nxt_frame_err;
        end
    end

    // Outputs
    assign pump = pump_ff;
    assign gate_enable = de_ff; // [R16]
    assign fault_clear = clr_ff; // [R8]
    assign overtemp_shutdown = ot_shut_ff;
    assign spread_spectrum_off = ssc_off_ff; // [R13]
    assign fault_pin_n_o = 1'b0; // Open drain: only ever pulls low
    assign fault_pin_n_oe = fault_low_ff; // [R12]
    assign crc_error = crc_err_ff;
    assign frame_error = frame_err_ff;

endmodule : gdc_ctrl_regs

// *** logic/gdc_pkg.sv ***
package gdc_pkg;

    // ----------------
    // Clock and timing
    // ----------------
    localparam int CLK_MHZ = 20;
    localparam int TRICKLE_SHORT_US = 100;
    localparam int TRICKLE_LONG_US = 250;
    localparam int TRICKLE_SHORT_CYC = TRICKLE_SHORT_US * CLK_MHZ;
    localparam int TRICKLE_LONG_CYC = TRICKLE_LONG_US * CLK_MHZ;
    localparam int TIMER_W = 13;

    // ----------------
    // Serial frame layout
    // ----------------
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam int CRC_W = 8;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] FRAME_BITS_PLAIN = 6'h18;
    localparam logic [CNT_W-1:0] FRAME_BITS_CRC = 6'h20;
    localparam logic [CNT_W-1:0] CMD_DONE_BITS = 6'h08;
    localparam int CMD_READ_BIT = 7;
    localparam int ADDR_W = 6;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // ----------------
    // Register map
    // ----------------
    localparam logic [ADDR_W-1:0] ADDR_IC_CONTROL_TWO = 6'h1B;
    localparam logic [ADDR_W-1:0] ADDR_IC_CONTROL_THREE = 6'h1C;
    localparam logic [15:0] IC_CONTROL_TWO_RST = 16'h0006;
    localparam logic [15:0] IC_CONTROL_THREE_RST = 16'h8001;

    // Second control register fields
    localparam int DRIVER_ENABLE_BIT = 15;
    localparam int PUMP_MODE_LSB = 6;
    localparam int LOCK_LSB = 1;
    localparam int FAULT_CLEAR_BIT = 0;
    localparam logic [2:0] LOCK_OPEN = 3'h3;
    localparam logic [2:0] LOCK_SHUT = 3'h6;
    localparam logic [1:0] PUMP_NORMAL = 2'h0;
    localparam logic [1:0] PUMP_PHASE_OFF = 2'h1;
    localparam logic [1:0] PUMP_SHUTDOWN = 2'h2;
    localparam logic [1:0] PUMP_NORMAL_NO_TRICKLE = 2'h3;

    // Third control register fields
    localparam int CRC_EN_BIT = 15;
    localparam int WARN_REPORT_BIT = 14;
    localparam int SSC_OFF_BIT = 12;
    localparam int TRICKLE_DLY_BIT = 10;
    localparam int OT_MODE_LSB = 0;
    localparam logic [1:0] OT_WARNING = 2'h0;
    localparam logic [1:0] OT_SHUTDOWN = 2'h1;

    // ----------------
    // Carriers
    // ----------------
    typedef struct packed {
        logic fault_latched;
        logic fault_present;
        logic driver_disable_pin;
        logic overtemp_event;
        logic warning_event;
        logic [2:0] high_side_pwm_in;
        logic [2:0] low_side_pwm_in;
    } gdc_pins_t;

    typedef struct packed {
        logic pump_clock_on;
        logic pump_to_phase_node_on;
        logic trickle_pump_switch_on;
        logic trickle_pump_run;
    } gdc_pump_t;

    typedef struct packed {
        logic [15:0] control_two;
        logic [15:0] control_three;
    } gdc_shadow_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [31:0] bits;
    } gdc_frame_t;

    // CRC over command and data, MSB first
    function automatic logic [7:0] gdc_crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : gdc_crc8

endpackage : gdc_pkg

// *** logic/gdc_spi_link.sv ***
`timescale 1ns/1ps
module gdc_spi_link
    import gdc_pkg::*;
(
    sclk,
    rst_n,
    cs_n,
    sdi,
    shadow,
    sdo_o,
    sdo_oe,
    frame
);
    input wire logic sclk;
    input wire logic rst_n;
    input wire logic cs_n;
    input wire logic sdi;
    input wire gdc_pkg::gdc_shadow_t shadow;
    output logic sdo_o;
    output logic sdo_oe;
    output gdc_pkg::gdc_frame_t frame;

    // ----------------
    // Receive side, rising edge of the link clock
    // ----------------
    logic armed_ff, nxt_armed;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [31:0] shift_ff, nxt_shift;
    logic arm_rst_n;

    // Select high re-arms without needing a link clock edge
    assign arm_rst_n = rst_n & ~cs_n;

    // Count is kept after the frame so the core can read it
    always_comb begin
        nxt_armed = 1'b0;
        nxt_shift = {shift_ff[30:0], sdi};
        if (armed_ff) begin
            nxt_cnt = 6'h01;
        end else if (cnt_ff == FRAME_BITS_CRC) begin
            nxt_cnt = cnt_ff;
        end else begin
            nxt_cnt = cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge sclk or negedge arm_rst_n) begin
        if (!arm_rst_n) begin
            armed_ff <= 1'b1;
        end else begin
            armed_ff <= nxt_armed;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            shift_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
        end
    end

    // ----------------
    // Transmit side, falling edge of the link clock
    // ----------------
    logic sdo_ff, nxt_sdo;
    logic [23:0] out_ff, nxt_out;
    logic [15:0] rd_data;
    logic [23:0] rd_word;

    // Shadow is frozen by the core while select is low [R11]
    always_comb begin
        rd_data = 16'h0000;
        if (shift_ff[ADDR_W-1:0] == ADDR_IC_CONTROL_TWO) begin
            rd_data = shadow.control_two;
        end else if (shift_ff[ADDR_W-1:0] == ADDR_IC_CONTROL_THREE) begin
            rd_data = shadow.control_three;
        end
        rd_word = {rd_data, gdc_crc8({shift_ff[7:0], rd_data})};
        nxt_sdo = 1'b0;
        nxt_out = out_ff;
        if (armed_ff) begin
            nxt_out = '0;
        end else if (cnt_ff == CMD_DONE_BITS) begin
            nxt_sdo = rd_word[23];
            nxt_out = {rd_word[22:0], 1'b0};
        end else if (cnt_ff > CMD_DONE_BITS) begin
            nxt_sdo = out_ff[23];
            nxt_out = {out_ff[22:0], 1'b0};
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_ff <= 1'b0;
            out_ff <= '0;
        end else begin
            sdo_ff <= nxt_sdo;
            out_ff <= nxt_out;
        end
    end

    assign sdo_o = sdo_ff;
    assign sdo_oe = ~cs_n;
    assign frame = '{count: cnt_ff, bits: shift_ff};

endmodule : gdc_spi_link

// *** test/gdc_host_model.sv ***
`timescale 1ns/1ps
module gdc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    output logic [15:0] rd,
    output logic rd_vld
);
    import gdc_pkg::*;

    // ------------
    // Serial host, link clock only inside a frame
    // ------------
    // Own CRC copy so a shared slip cannot hide
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    // One frame, MSB first, sdi moves after falling sclk
    task automatic xfer(input logic [23:0] f, input int nb, input logic bad);
        logic [31:0] w;
        w = {f, crc8(f) ^ {7'h00, bad}};
        cs_n = 1'b0;
        #200;
        for (int i = 0; i < nb; i++) begin
            sdi = w[31-i];
            #16 sclk = 1'b1;
            if (i > 7 && i < 24) rd[23-i] = sdo;
            #16 sclk = 1'b0;
        end
        cs_n = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit
        rd_vld = f[23];
        #50 rd_vld = 1'b0;
        #700; // Idle gap over 4 cycles
    endtask : xfer

    // Idle levels
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        rd = 16'h0000;
        rd_vld = 1'b0;
    end
endmodule : gdc_host_model

// *** test/gdc_ctrl_regs_props.sv ***
`timescale 1ns/1ps
module gdc_ctrl_regs_props (
    input logic clk,
    input logic rstn,
    input logic cs_n,
    input logic sdo_oe,
    input gdc_pkg::gdc_pins_t pins,
    input gdc_pkg::gdc_pump_t pump,
    input logic gate_enable,
    input logic fault_clear,
    input logic overtemp_shutdown,
    input logic fault_pin_n_o,
    input logic fault_pin_n_oe,
    input logic crc_error,
    input logic frame_error
);
    // ------------
    // Port relations, margins cover the pin sync
    // ------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_disable_pin_off: assert property (pins.driver_disable_pin [*4] |-> !gate_enable)
        else $error("gate on, pin");
    a_fault_gate_off: assert property (pins.fault_present [*4] |-> !gate_enable)
        else $error("gate on, fault");
    a_phase_needs_clk: assert property (pump.pump_to_phase_node_on |-> pump.pump_clock_on)
        else $error("phase w/o clock");
    a_clear_one_pulse: assert property (fault_clear |=> !fault_clear)
        else $error("clear too long");
    a_clear_after_frame: assert property (fault_clear |-> cs_n && $past(cs_n, 2))
        else $error("clear in frame");
    a_error_pulse: assert property (frame_error || crc_error |-> cs_n ##1 !frame_error)
        else $error("error pulse");
    a_pin_low_only: assert property (!fault_pin_n_o)
        else $error("pin driven high");
    a_latched_pin: assert property (pins.fault_latched [*4] |-> fault_pin_n_oe)
        else $error("latched not shown");
    a_shutdown_pin: assert property (overtemp_shutdown |-> ##[0:2] fault_pin_n_oe)
        else $error("shutdown not shown");
    a_oe_select: assert property (sdo_oe == !cs_n)
        else $error("sdo enable");

    c_clear: cover property (fault_clear);
    c_crc_err: cover property (crc_error);
    c_shutdown: cover property (overtemp_shutdown && fault_pin_n_oe);
endmodule : gdc_ctrl_regs_props

bind gdc_ctrl_regs gdc_ctrl_regs_props u_gdc_ctrl_regs_props (
    .clk, .rstn, .cs_n, .sdo_oe, .pins, .pump, .gate_enable, .fault_clear,
    .overtemp_shutdown, .fault_pin_n_o, .fault_pin_n_oe, .crc_error, .frame_error
);

// *** test/gdc_ctrl_regs_tb.sv ***
`timescale 1ns/1ps
module gdc_ctrl_regs_tb;
    import gdc_pkg::*;
    logic clk, rstn, sclk, cs_n, sdi, sdo_o, sdo_oe, rd_vld, en;
    logic fault_clear, ot_sd, ssc_off, fp_o, fp_oe, crc_error, frame_error, gate;
    logic [15:0] rd, d;
    logic [1:0] m;
    gdc_pins_t pins;
    gdc_pump_t pump;
    int error_cnt, n_compared, seed, nb, n_clr, n_ce, n_fe;
    logic [15:0] q[$];

    // ------------
    // Harness: long trickle limit cut to 40 cycles keeps the run brief
    // ------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    gdc_ctrl_regs #(.TRICKLE_LONG(40)) u_gdc_ctrl_regs (
        .clk, .rstn, .sclk, .cs_n, .sdi, .sdo_o, .sdo_oe, .pins, .pump, .gate_enable(gate),
        .fault_clear, .overtemp_shutdown(ot_sd), .spread_spectrum_off(ssc_off),
        .fault_pin_n_o(fp_o), .fault_pin_n_oe(fp_oe), .crc_error, .frame_error);

    gdc_host_model u_gdc_host_model (.sclk, .cs_n, .sdi, .sdo(sdo_oe ? sdo_o : ~sdo_o), .rd,
        .rd_vld);

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        u_gdc_host_model.xfer({2'b00, a, v}, nb, 1'b0);
    endtask : wr

    // Note the expected readback, then read
    task automatic rdq(input logic [5:0] a, input logic [15:0] e);
        q.push_back(e);
        u_gdc_host_model.xfer({2'b10, a, 16'h0000}, nb, 1'b0);
    endtask : rdq

    task automatic stop_test();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // Readback checker, oldest note first
    always @(posedge rd_vld) chk("readback", q.pop_front(), rd);

    // Pulse counters, an unknown never counts
    always @(posedge clk) begin
        n_clr += (fault_clear === 1'b1);
        n_ce += (crc_error === 1'b1);
        n_fe += (frame_error === 1'b1);
    end

    // Watchdog
    initial begin
        #1_000_000;
        error_cnt++;
        stop_test();
    end

    // ------------
    // Scenarios
    // ------------
    initial begin
        {error_cnt, n_compared, n_clr, n_ce, n_fe} = '0;
        seed = 77;
        nb = 32;
        pins = '0;
        pins.high_side_pwm_in = 3'h5;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (4) @(negedge clk);
        rdq(ADDR_IC_CONTROL_TWO, IC_CONTROL_TWO_RST);
        rdq(ADDR_IC_CONTROL_THREE, IC_CONTROL_THREE_RST);
        u_gdc_host_model.xfer({2'b00, ADDR_IC_CONTROL_THREE, 16'h0000}, 32, 1'b1);
        chk("crc_error", 16'h0001, 16'(n_ce));
        rdq(ADDR_IC_CONTROL_THREE, IC_CONTROL_THREE_RST);
        @(negedge clk) pins.overtemp_event = 1'b1;
        // Report bit, spread spectrum and overtemp modes, random reserved bits
        for (int i = 0; i < 8; i++) begin
            d = (16'($random(seed)) & 16'h2BFC) | {1'b0, i[2], 1'b0, i[2], 10'h000, i[1:0]};
            wr(ADDR_IC_CONTROL_THREE, d);
            nb = 24;
            rdq(ADDR_IC_CONTROL_THREE, d & 16'h5403);
            chk("ot_shutdown", 16'(i[1:0] == 2'h1), 16'(ot_sd));
            chk("fault_pin", 16'(i[1:0] == 2'h1 || (i[1:0] == 2'h0 && i[2])), 16'(fp_oe));
            chk("ssc_off", 16'(i[2]), 16'(ssc_off));
        end
        @(negedge clk) pins.overtemp_event = 1'b0;
        u_gdc_host_model.xfer({2'b00, ADDR_IC_CONTROL_THREE, 16'h0000}, 23, 1'b0);
        chk("frame_error", 16'h0001, 16'(n_fe));
        rdq(ADDR_IC_CONTROL_THREE, d & 16'h5403);
        // Every pump mode with the enable bit low and high
        for (int i = 0; i < 8; i++) begin
            m = i[1:0];
            en = i[2];
            wr(ADDR_IC_CONTROL_TWO, {en, 7'h00, m, 6'h06});
            chk("pump", {12'h000, m != 2'h2, m == 2'h0 || m == 2'h3,
                (m == 2'h3) ? en : (m != 2'h2 && !en), 1'b0}, 16'(pump));
            chk("gate_enable", 16'(en), 16'(gate));
        end
        wr(ADDR_IC_CONTROL_TWO, 16'h0006);
        @(negedge clk) {pins.driver_disable_pin, pins.fault_present} = 2'b11;
        repeat (8) @(negedge clk);
        chk("gate_enable", 16'h0000, 16'(gate));
        chk("trickle_sw", 16'h0001, 16'(pump.trickle_pump_switch_on));
        {pins.driver_disable_pin, pins.fault_present, pins.fault_latched} = 3'b001;
        repeat (4) @(negedge clk);
        wr(ADDR_IC_CONTROL_TWO, 16'h8007);
        chk("fault_clear", 16'h0001, 16'(n_clr));
        chk("gate_enable", 16'h0000, 16'(gate));
        @(negedge clk) pins.fault_latched = 1'b0;
        wr(ADDR_IC_CONTROL_TWO, 16'h8006);
        chk("gate_enable", 16'h0001, 16'(gate));
        chk("fault_clear", 16'h0001, 16'(n_clr));
        // Lock, ignored writes, unknown code, unlock
        wr(ADDR_IC_CONTROL_TWO, 16'h800C);
        wr(ADDR_IC_CONTROL_THREE, 16'h0000);
        rdq(ADDR_IC_CONTROL_THREE, d & 16'h5403);
        wr(ADDR_IC_CONTROL_TWO, 16'h00CA);
        rdq(ADDR_IC_CONTROL_TWO, 16'h800C);
        wr(ADDR_IC_CONTROL_TWO, 16'h0006);
        rdq(ADDR_IC_CONTROL_TWO, 16'h8006);
        wr(ADDR_IC_CONTROL_TWO, 16'h0006);
        rdq(ADDR_IC_CONTROL_TWO, 16'h0006);
        // Trickle start delay, short and long
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_IC_CONTROL_THREE, {5'h00, j[0], 10'h000});
            @(negedge clk) pins.high_side_pwm_in = 3'h0;
            repeat ((j == 1) ? 30 : 1990) @(negedge clk);
            chk("trickle_run", 16'h0000, 16'(pump.trickle_pump_run));
            repeat (20) @(negedge clk);
            chk("trickle_run", 16'h0001, 16'(pump.trickle_pump_run));
            pins.high_side_pwm_in = 3'h5;
        end
        stop_test();
    end
endmodule : gdc_ctrl_regs_tb
